// ===== logic/csm_channel.sv
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
// Overview of operation
// R1 - Slave transmit shifts only on the peer's serial clock, never its own.
// R2 - Interrupt is frame end in single mode, buffer empty in continuous mode.
// R3 - Overrun is the only error; it sets a dedicated overrun flag. The code sets the flag in master mode only.
// R4 - Sampled slave clock works up to one sixth of the core clock.
// R5 - Data phase 0 outputs at first clock edge; 1 outputs half period earlier.
// R6 - Clock polarity 0 gives non-inverted clock, 1 inverted clock.
// R7 - Writing data while buffer full replaces the pending transmit byte.
// R8 - Reading data while buffer full returns transmit byte, transfer untouched.
// R9 - Software changes interrupt select before the last bit starts.
// R10 - Software sets clock, mode, format, levels, enables, then start bit.
// R11 - Writing start trigger sets the running status bit.
// R12 - In master mode a data write of bits 7..0 starts a transfer.
// R13 - Before resuming, software waits for idle and disables pin outputs.
// R14 - Writing the flag clear trigger clears the overrun flag.
// R15 - Output enable 0 stops serial output; 1 enables it again.
// R16 - Level register holds clock levels in 11..8, data levels in 3..0.
// R17 - On resume, software restores pin enables, starts, then writes data.
// R18 - Data length 0 gives 7-bit frames, 1 gives 8-bit frames.
// R19 - Order bit 0 shifts MSB first, 1 shifts LSB first.
// R20 - Master generates the serial clock and shifts out and in together.
// R21 - Frame start moves buffer to shifter, clears full flag, raises empty irq.

// Three-stage input sampler, level accepted once stages two and three agree
module csm_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    output logic      lvl_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_o <= 1'b1;
        end
        else
        begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                lvl_o <= s3_q;
        end
    end
endmodule : csm_sync

module csm_channel (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Serial pins
    input  wire logic              sclk_i,
    input  wire logic              sdata_i,
    output csm_pkg::csm_pins_t     pin_o,
    // Channel interrupt
    output logic                   irq_o
);
    import csm_pkg::*;

    logic [1:0]  mode_q;
    logic [15:0] comm_q;
    logic [15:0] olvl_q;
    logic        oen_q;
    logic        run_q;
    logic        bff_q;
    logic        ovf_q;
    logic        rxf_q;
    logic [7:0]  buf_q;
    logic [7:0]  rxd_q;
    logic [7:0]  tsh_q;
    logic [7:0]  rsh_q;
    logic        tbit_q;
    logic [3:0]  ecnt_q;
    logic [7:0]  div_q;
    logic        tog_q;
    logic        lvl_q;
    csm_state_t  st_q;
    logic        sclk_s;
    logic        sdi_s;

    csm_sync u_sclk (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (sclk_i),
        .lvl_o      (sclk_s)
    );

    csm_sync u_sdi (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (sdata_i),
        .lvl_o      (sdi_s)
    );

    // Bus decode; pready_o inserts one wait state so read data is registered
    logic acc;
    logic wr;
    logic mapped;
    assign acc    = psel_i & penable_i & pready_o;
    assign wr     = acc & pwrite_i;
    assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= CSM_OFF_OEN);

    logic wr_data;
    logic rd_data;
    logic wr_fclr;
    logic wr_go;
    assign wr_data = wr && paddr_i == CSM_OFF_DATA;
    assign rd_data = acc && !pwrite_i && paddr_i == CSM_OFF_DATA;
    assign wr_fclr = wr && paddr_i == CSM_OFF_FCLR;
    assign wr_go   = wr && paddr_i == CSM_OFF_START;

    logic slv;
    logic ckp;
    logic dap;
    logic lsb;
    logic len8;
    assign slv  = mode_q[CSM_MODE_SLV];
    assign ckp  = comm_q[CSM_COMM_CKP];
    assign dap  = comm_q[CSM_COMM_DAP];
    assign lsb  = comm_q[CSM_COMM_LSB];
    assign len8 = comm_q[CSM_COMM_LEN8];

    // Edge events of the serial clock, own or peer's
    logic slv_edge;
    logic edge_ev;
    logic lead;
    logic last;
    logic launch;
    logic load;
    assign slv_edge = sclk_s != lvl_q;
    assign edge_ev  = (st_q == CSM_SHIFT) && (slv ? slv_edge : div_q == 8'h00); // R1 R20
    assign lead     = ~ecnt_q[0];
    assign last     = edge_ev && ecnt_q == (len8 ? CSM_LAST_E8 : CSM_LAST_E7); // R18
    assign launch   = dap ? ~lead : lead; // R5
    assign load     = run_q && bff_q && (st_q == CSM_IDLE || last); // R12 R21

    function automatic logic out_bit(input logic [7:0] sh, input logic l, input logic e8);
        out_bit = l ? sh[0] : (e8 ? sh[7] : sh[6]); // R19
    endfunction : out_bit

    function automatic logic [7:0] shift_tx(input logic [7:0] sh, input logic l);
        shift_tx = l ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
    endfunction : shift_tx

    logic [7:0] rsh_d;
    logic [7:0] rx_word;
    always_comb
    begin
        rsh_d = rsh_q;
        if (edge_ev && !launch)
            rsh_d = lsb ? {sdi_s, rsh_q[7:1]} : {rsh_q[6:0], sdi_s};
        if (len8)
            rx_word = rsh_d;
        else
            rx_word = lsb ? {1'b0, rsh_d[7:1]} : {1'b0, rsh_d[6:0]}; // R18
    end

    // Registers written by software
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= CSM_MODE_RST;
            comm_q <= CSM_COMM_RST;
            olvl_q <= CSM_OLVL_RST;
            oen_q  <= CSM_OEN_RST;
        end
        else if (wr)
        begin
            if (paddr_i == CSM_OFF_MODE)
                mode_q <= pwdata_i[1:0]; // R9
            if (paddr_i == CSM_OFF_COMM)
                comm_q <= pwdata_i[15:0];
            if (paddr_i == CSM_OFF_OLVL)
                olvl_q <= pwdata_i[15:0] & 16'h0f0f; // R16
            if (paddr_i == CSM_OFF_OEN)
                oen_q <= pwdata_i[0]; // R15
        end
    end

    // Running status
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            run_q <= 1'b0;
        else if (wr_go && pwdata_i[CSM_GO_BIT])
            run_q <= 1'b1; // R11
        else if (wr_go && pwdata_i[CSM_STOP_BIT])
            run_q <= 1'b0;
    end

    // Transmit buffer; a new write always wins over the load
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            bff_q <= 1'b0;
            buf_q <= 8'h00;
        end
        else if (wr_data)
        begin
            bff_q <= 1'b1; // R7
            buf_q <= pwdata_i[7:0];
        end
        else if (load)
            bff_q <= 1'b0; // R21
    end

    // Receive holding and overrun
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rxd_q <= 8'h00;
            rxf_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            if (last)
            begin
                rxd_q <= rx_word;
                rxf_q <= 1'b1;
            end
            else if (rd_data && !bff_q)
                rxf_q <= 1'b0;
            if (last && rxf_q && !slv)
                ovf_q <= 1'b1; // R3
            else if (wr_fclr && pwdata_i[CSM_STAT_OVF])
                ovf_q <= 1'b0; // R14
        end
    end

    // Shift engine
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q   <= CSM_IDLE;
            tsh_q  <= 8'h00;
            rsh_q  <= 8'h00;
            tbit_q <= 1'b1;
            ecnt_q <= 4'h0;
            div_q  <= 8'h00;
            tog_q  <= 1'b0;
        end
        else
        begin
            rsh_q  <= rsh_d;
            if (!run_q)
                st_q <= CSM_IDLE;
            else if (load)
            begin
                st_q   <= CSM_SHIFT;
                ecnt_q <= 4'h0;
                tog_q  <= 1'b0;
                div_q  <= comm_q[15:CSM_COMM_DIV];
                if (dap)
                begin
                    tbit_q <= out_bit(buf_q, lsb, len8); // R5
                    tsh_q  <= shift_tx(buf_q, lsb);
                end
                else
                    tsh_q <= buf_q;
            end
            else if (last)
                st_q <= CSM_IDLE;
            else if (st_q == CSM_SHIFT)
            begin
                if (!slv)
                    div_q <= edge_ev ? comm_q[15:CSM_COMM_DIV] : div_q - 8'h01; // R20
                if (edge_ev)
                begin
                    ecnt_q <= ecnt_q + 4'h1;
                    tog_q  <= ~tog_q;
                    if (launch)
                    begin
                        tbit_q <= out_bit(tsh_q, lsb, len8);
                        tsh_q  <= shift_tx(tsh_q, lsb);
                    end
                end
            end
        end
    end

    // Peer clock level tracking, idle level follows polarity
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            lvl_q <= 1'b1;
        else if (st_q == CSM_IDLE)
            lvl_q <= ~ckp; // R6
        else if (slv && slv_edge)
            lvl_q <= sclk_s; // R1 R4
    end

    // Pins and interrupt, all registered
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pin_o <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            pin_o.sdata_oe <= oen_q; // R15
            pin_o.sclk_oe  <= oen_q && !slv; // R1
            if (st_q == CSM_SHIFT && !slv)
                pin_o.sclk <= ~ckp ^ tog_q; // R6 R20
            else
                pin_o.sclk <= olvl_q[CSM_OLVL_CLK]; // R16
            if (st_q == CSM_SHIFT && (dap || ecnt_q != 4'h0))
                pin_o.sdata <= tbit_q;
            else
                pin_o.sdata <= olvl_q[CSM_OLVL_DAT]; // R16
            irq_o <= mode_q[CSM_MODE_ISEL] ? load : last; // R2
        end
    end

    // Bus answer
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (paddr_i)
            CSM_OFF_DATA:  rd_val = {24'h00_0000, bff_q ? buf_q : rxd_q}; // R8
            CSM_OFF_MODE:  rd_val = {30'h0, mode_q};
            CSM_OFF_COMM:  rd_val = {16'h0000, comm_q};
            CSM_OFF_STAT:  rd_val = {28'h0, run_q, st_q == CSM_SHIFT, bff_q, ovf_q};
            CSM_OFF_OLVL:  rd_val = {16'h0000, olvl_q};
            CSM_OFF_OEN:   rd_val = {31'h0, oen_q};
            default:       rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
            prdata_o  <= rd_val;
        end
    end

    slave_no_clk_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R1
        $past(slv) |-> !pin_o.sclk_oe)
        else $error("slave drives its serial clock");
    irq_select_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R2
        (last && !mode_q[CSM_MODE_ISEL] && !wr) |=> irq_o)
        else $error("frame end interrupt missing");
    overrun_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R3
        (last && rxf_q && !slv) |=> ovf_q)
        else $error("overrun not flagged");
    overwrite_buf_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R7
        (wr_data && bff_q) |=> bff_q && buf_q == $past(pwdata_i[7:0]))
        else $error("pending byte not replaced");
    read_tx_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R8
        (rd_data && bff_q) |=> prdata_o[7:0] == $past(buf_q))
        else $error("data read did not return pending byte");
    start_run_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
        (wr_go && pwdata_i[CSM_GO_BIT]) |=> run_q)
        else $error("start trigger did not enable channel");
    master_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
        (wr_data && run_q && !slv && st_q == CSM_IDLE) |=> ##1 st_q == CSM_SHIFT)
        else $error("data write did not start transfer");
    flag_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R14
        (wr_fclr && pwdata_i[CSM_STAT_OVF] && !last) |=> !ovf_q)
        else $error("overrun flag not cleared");
    out_disable_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R15
        (!oen_q ##1 !oen_q) |-> !pin_o.sdata_oe)
        else $error("serial output not stopped");
    idle_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R16
        (st_q == CSM_IDLE && !load) |=> pin_o.sdata == $past(olvl_q[CSM_OLVL_DAT]))
        else $error("idle data level wrong");
    early_data_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R5
        (load && dap) |=> tbit_q == out_bit($past(buf_q), lsb, len8))
        else $error("first bit not presented early");
endmodule : csm_channel

// ===== logic/csm_pkg.sv
package csm_pkg;
    localparam int          CSM_AW        = 8;
    // Register byte offsets
    localparam logic [7:0]  CSM_OFF_DATA  = 8'h00;
    localparam logic [7:0]  CSM_OFF_MODE  = 8'h04;
    localparam logic [7:0]  CSM_OFF_COMM  = 8'h08;
    localparam logic [7:0]  CSM_OFF_STAT  = 8'h0c;
    localparam logic [7:0]  CSM_OFF_FCLR  = 8'h10;
    localparam logic [7:0]  CSM_OFF_START = 8'h14;
    localparam logic [7:0]  CSM_OFF_OLVL  = 8'h18;
    localparam logic [7:0]  CSM_OFF_OEN   = 8'h1c;
    // Field positions
    localparam int          CSM_MODE_ISEL = 0;
    localparam int          CSM_MODE_SLV  = 1;
    localparam int          CSM_COMM_CKP  = 0;
    localparam int          CSM_COMM_DAP  = 1;
    localparam int          CSM_COMM_LSB  = 2;
    localparam int          CSM_COMM_LEN8 = 3;
    localparam int          CSM_COMM_DIV  = 8;
    localparam int          CSM_STAT_OVF  = 0;
    localparam int          CSM_STAT_BFF  = 1;
    localparam int          CSM_STAT_BUSY = 2;
    localparam int          CSM_STAT_RUN  = 3;
    localparam int          CSM_GO_BIT    = 0;
    localparam int          CSM_STOP_BIT  = 1;
    localparam int          CSM_OLVL_CLK  = 8;
    localparam int          CSM_OLVL_DAT  = 0;
    // Values after reset
    localparam logic [1:0]  CSM_MODE_RST  = 2'h0;
    localparam logic [15:0] CSM_COMM_RST  = 16'h0008;
    localparam logic [15:0] CSM_OLVL_RST  = 16'h0f0f;
    localparam logic        CSM_OEN_RST   = 1'h0;
    // Edge counts per frame, last edge index
    localparam logic [3:0]  CSM_LAST_E8   = 4'hf;
    localparam logic [3:0]  CSM_LAST_E7   = 4'hd;
    // Slave clock may run at most at core rate over this
    localparam int          CSM_SLV_DIV   = 6;

    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic sdata;
        logic sdata_oe;
    } csm_pins_t;

    typedef enum logic {CSM_IDLE, CSM_SHIFT} csm_state_t;
endpackage : csm_pkg

// ===== sim/csm_peer.sv
`timescale 1ns/1ns
module csm_peer
    import csm_pkg::*;
(
    // Clock and pins
    input  wire logic          clk_i,
    input  wire csm_pkg::csm_pins_t pin_i,
    // Peer drives
    output logic               sclk_o,
    output logic               sdata_o
);
    csm_pins_t   prev_q;
    logic        idle_q;
    logic        dap_q;
    logic        armed_q;
    logic [7:0]  rsh_q;
    logic [15:0] cap_q;
    int          cnt_q;

    initial
    begin
        sclk_o  = 1'b1;
        sdata_o = 1'b0;
        armed_q = 1'b0;
        cap_q   = 16'h0000;
        cnt_q   = 0;
    end

    task automatic arm(input logic dap, input logic [7:0] reply);
        idle_q  = pin_i.sclk;
        dap_q   = dap;
        cap_q   = 16'h0000;
        cnt_q   = 0;
        rsh_q   = dap ? {reply[6:0], ~reply[7]} : reply;
        sdata_o <= dap ? reply[7] : ~sdata_o;
        armed_q = 1'b1;
    endtask : arm

    // Takes the bit held before each edge, as a real slave would
    always @(posedge clk_i)
    begin
        prev_q <= pin_i;
        if (armed_q && pin_i.sclk_oe && prev_q.sclk_oe && pin_i.sclk != prev_q.sclk)
        begin
            if ((pin_i.sclk != idle_q) == dap_q)
            begin
                cap_q <= {cap_q[14:0], prev_q.sdata};
                cnt_q <= cnt_q + 1;
            end
            else
            begin
                sdata_o <= rsh_q[7];
                rsh_q   <= {rsh_q[6:0], ~rsh_q[7]};
            end
        end
    end

    // Clock runs only inside the frame; long low half covers the sampler lag
    task automatic slave_frame(input int n);
        for (int i = 0; i < n; i++)
        begin
            sclk_o <= 1'b0;
            #80;
            cap_q = {cap_q[14:0], pin_i.sdata};
            cnt_q = cnt_q + 1;
            sclk_o <= 1'b1;
            #45;
        end
    endtask : slave_frame
endmodule : csm_peer

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import csm_pkg::*;
    logic        core_clk_i;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        sclk_i;
    logic        sdata_i;
    csm_pins_t   pin_o;
    logic        irq_o;
    logic [31:0] rdat;
    logic        rerr;
    int          error_cnt;
    int          n_tests;
    int          irq_cnt;

    csm_channel csm_channel_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_i(sclk_i),
        .sdata_i(sdata_i), .pin_o(pin_o), .irq_o(irq_o));
    csm_peer csm_peer_i (.clk_i(core_clk_i), .pin_i(pin_o), .sclk_o(sclk_i), .sdata_o(sdata_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Falling edge: the registered pulse is settled, no race with the tasks
    always @(negedge core_clk_i)
    begin
        if (irq_o === 1'b1)
            irq_cnt++;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1)
            chk("pready", 32'h1, {31'h0, pready_o});
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rchk

    task automatic wait_irq(input int b, input int lim);
        int n;
        n = 0;
        while (irq_cnt == b && n < lim)
        begin
            @(posedge core_clk_i);
            n++;
        end
        chk("irq", 32'h1, 32'(irq_cnt - b));
    endtask : wait_irq

    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, CSM_OFF_STAT, 32'h0);
            n++;
        end
        while (rdat[CSM_STAT_BUSY] !== 1'b0 && n < 100);
    endtask : wait_idle

    task automatic t_rst();
        rchk("comm", CSM_OFF_COMM, 32'h8);
        rchk("olvl", CSM_OFF_OLVL, 32'hf0f);
        rchk("oen", CSM_OFF_OEN, 32'h0);
        rchk("stat", CSM_OFF_STAT, 32'h0);
        rchk("gap", 8'h20, 32'h0);
        chk("gap_err", 32'h1, {31'h0, rerr});
        chk("pins", 32'ha, {28'h0, pin_o});
        $display("test reset done");
    endtask : t_rst

    task automatic t_mst();
        int b;
        apb(1'b1, CSM_OFF_COMM, 32'h708);
        apb(1'b1, CSM_OFF_OEN, 32'h1);
        apb(1'b1, CSM_OFF_START, 32'h1);
        rchk("run", CSM_OFF_STAT, 32'h8);
        csm_peer_i.arm(1'b0, 8'h3c);
        b = irq_cnt;
        apb(1'b1, CSM_OFF_DATA, 32'hffff_ffa5);
        wait_irq(b, 300);
        // Peer sees the final clock edge only after the interrupt
        wait_idle();
        chk("tx", 32'ha5, {16'h0, csm_peer_i.cap_q});
        chk("bits", 32'h8, 32'(csm_peer_i.cnt_q));
        rchk("rx", CSM_OFF_DATA, 32'h3c);
        $display("test master done");
    endtask : t_mst

    task automatic t_fmt();
        int          b;
        logic [31:0] e;
        logic [7:0]  d;
        e = 32'h0;
        d = 8'h5a;
        for (int i = 0; i < 7; i++)
            e = {e[30:0], d[i]};
        apb(1'b1, CSM_OFF_COMM, 32'h707);
        // Idle clock level must match the inverted polarity
        apb(1'b1, CSM_OFF_OLVL, 32'h00f);
        repeat (3) @(posedge core_clk_i);
        chk("cpol", 32'h0, {31'h0, pin_o.sclk});
        csm_peer_i.arm(1'b1, 8'h00);
        b = irq_cnt;
        apb(1'b1, CSM_OFF_DATA, {24'h0, d});
        wait_irq(b, 300);
        chk("lsb7", e, {16'h0, csm_peer_i.cap_q});
        chk("bits7", 32'h7, 32'(csm_peer_i.cnt_q));
        wait_idle();
        apb(1'b0, CSM_OFF_DATA, 32'h0);
        $display("test format done");
    endtask : t_fmt

    task automatic t_cont();
        int b;
        apb(1'b1, CSM_OFF_START, 32'h2);
        apb(1'b1, CSM_OFF_OLVL, 32'hf0f);
        apb(1'b1, CSM_OFF_COMM, 32'h708);
        apb(1'b1, CSM_OFF_MODE, 32'h1);
        apb(1'b1, CSM_OFF_DATA, 32'h11);
        apb(1'b1, CSM_OFF_DATA, 32'h22);
        rchk("bff", CSM_OFF_STAT, 32'h2);
        rchk("over", CSM_OFF_DATA, 32'h22);
        csm_peer_i.arm(1'b0, 8'h00);
        b = irq_cnt;
        apb(1'b1, CSM_OFF_START, 32'h1);
        wait_irq(b, 20);
        rchk("load", CSM_OFF_STAT, 32'hc);
        b = irq_cnt;
        apb(1'b1, CSM_OFF_DATA, 32'h33);
        rchk("rdtx", CSM_OFF_DATA, 32'h33);
        wait_irq(b, 300);
        wait_idle();
        chk("cont", 32'h2233, {16'h0, csm_peer_i.cap_q});
        rchk("ovf", CSM_OFF_STAT, 32'h9);
        apb(1'b1, CSM_OFF_FCLR, 32'h1);
        rchk("fclr", CSM_OFF_STAT, 32'h8);
        apb(1'b0, CSM_OFF_DATA, 32'h0);
        $display("test continuous done");
    endtask : t_cont

    task automatic t_oen();
        apb(1'b1, CSM_OFF_START, 32'h2);
        apb(1'b1, CSM_OFF_OEN, 32'h0);
        apb(1'b1, CSM_OFF_OLVL, 32'h0);
        rchk("olvl0", CSM_OFF_OLVL, 32'h0);
        chk("pins0", 32'h0, {28'h0, pin_o});
        apb(1'b1, CSM_OFF_OLVL, 32'hf0f);
        apb(1'b1, CSM_OFF_OEN, 32'h1);
        repeat (3) @(posedge core_clk_i);
        chk("pins1", 32'hf, {28'h0, pin_o});
        $display("test enables done");
    endtask : t_oen

    task automatic t_slv();
        int b;
        apb(1'b1, CSM_OFF_MODE, 32'h2);
        apb(1'b1, CSM_OFF_START, 32'h1);
        csm_peer_i.arm(1'b0, 8'h00);
        b = irq_cnt;
        apb(1'b1, CSM_OFF_DATA, 32'hc3);
        repeat (40) @(posedge core_clk_i);
        chk("noclk", 32'h0, 32'(irq_cnt - b));
        chk("sckoe", 32'h0, {31'h0, pin_o.sclk_oe});
        csm_peer_i.slave_frame(8);
        @(posedge core_clk_i);
        wait_irq(b, 20);
        chk("slv", 32'hc3, {16'h0, csm_peer_i.cap_q});
        $display("test slave done");
    endtask : t_slv

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        error_cnt = 0;
        n_tests   = 0;
        irq_cnt   = 0;
        rst_i     = 1'b1;
        psel_i    = 1'b0;
        penable_i = 1'b0;
        pwrite_i  = 1'b0;
        paddr_i   = 8'h00;
        pwdata_i  = 32'h0;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_rst();
        t_mst();
        t_fmt();
        t_cont();
        t_oen();
        t_slv();
        end_of_test();
    end

    // Run needs about 1000 cycles; allow 25 times that
    initial
    begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule : tb_top
